// >>> design/dwss_pkg.sv
// Constants and carrier types for the write saturation and barrel shifter slice.
// Assumes a single core clock; all requests come from logic on that clock.
//
// How it works
// RQ1 - Saturation alters stored word, never the accumulator
// RQ2 - Rounded 1.15 value plus overflow flags
// RQ3 - Overflow test acts on already rounded data
// RQ4 - Positive overflow stores maximum positive fraction
// RQ5 - Negative overflow stores maximum negative fraction
// RQ6 - Operand sign comes from accumulator bit 39
// RQ7 - Saturation disabled passes rounded value unchanged
// RQ8 - Shift up to sixteen bits in one cycle
// RQ9 - Operand from either accumulator or X bus
// RQ10 - Positive amount right, negative left, zero none
// RQ11 - Forty-bit datapath, forty and sixteen bit results
// RQ12 - X data placed per shift direction
// RQ13 - Arithmetic fills sign, others fill zero
package dwss_pkg;

   // Datapath widths
   localparam int DATA_W       = 16;
   localparam int ACC_W        = 40;
   localparam int AMT_W        = 6;
   localparam int MAG_W        = 5;

   // Saturation limits and sign position
   localparam logic [15:0] SAT_MAX_POS  = 16'h7fff;
   localparam logic [15:0] SAT_MAX_NEG  = 16'h8000;
   localparam int          ACC_SIGN_BIT = 39;

   // Largest shift magnitude taken in one cycle
   localparam logic [4:0]  SHIFT_MAX    = 5'h10;

   // X bus placement in the forty-bit operand
   localparam int XBUS_RIGHT_LSB = 16;
   localparam int XBUS_LEFT_LSB  = 0;

   // Reset values of the output state
   localparam logic [15:0] RST_WR_DATA  = 16'h0000;
   localparam logic [39:0] RST_SHF_RES  = 40'h00_0000_0000;
   localparam logic [15:0] RST_SHF_MCU  = 16'h0000;

   // Shifter operand sources; the fourth code is illegal
   typedef enum logic [1:0] {
      DWSS_SRC_ACC_A = 2'h0,
      DWSS_SRC_ACC_B = 2'h1,
      DWSS_SRC_XBUS  = 2'h2
   } dwss_src_type;

   // Store request from the round logic
   typedef struct packed {
      logic        valid;
      logic [15:0] rnd_value;
      logic [39:0] src_acc;
      logic        acc_ovf;
      logic        rnd_ovf;
   } dwss_sat_req_type;

   // Shift request
   typedef struct packed {
      logic         valid;
      dwss_src_type src_sel;
      logic         arith;
      logic [5:0]   amount;
      logic [39:0]  acc_a;
      logic [39:0]  acc_b;
      logic [15:0]  xbus;
   } dwss_shf_req_type;

   // Whole state of the slice
   typedef struct packed {
      logic        wr_valid;
      logic [15:0] wr_data;
      logic        wr_sat;
      logic        shf_valid;
      logic [39:0] shf_res;
      logic [15:0] shf_mcu;
   } dwss_state_type;

endpackage

// >>> design/dwss_top.sv
// Data space write saturation stage and forty-bit single-cycle barrel shifter.
// Assumes the accumulators, round logic and X bus sit on the same clock, so no
// input is synchronised; results appear one clock after the request.
`timescale 1ns/100ps

module dwss_top
(
   input  wire logic                      CLK_I,
   input  wire logic                      RST_N_I,
   input  wire logic                      CE_I,
   input  wire logic                      DATA_WRITE_SATURATION_ENABLE_I,
   input  wire dwss_pkg::dwss_sat_req_type SAT_REQ_I,
   input  wire dwss_pkg::dwss_shf_req_type SHF_REQ_I,
   output wire logic                      WR_VALID_O,
   output wire logic [15:0]               WR_DATA_O,
   output wire logic                      WR_SAT_O,
   output wire logic                      SHF_VALID_O,
   output wire logic [39:0]               SHF_RES_O,
   output wire logic [15:0]               SHF_MCU_O
);

   dwss_pkg::dwss_state_type state_reg;
   dwss_pkg::dwss_state_type state_next;

   // Saturation choice: returns {saturated flag, stored word}
   function automatic logic [16:0] dwss_saturate
   (
      input logic [15:0] value,
      input logic        sign,
      input logic        ovf,
      input logic        enable
   );
      logic [16:0] res;
      res = {1'b0, value};
      if (enable && ovf)
      begin
         res = sign ? {1'b1, dwss_pkg::SAT_MAX_NEG} : {1'b1, dwss_pkg::SAT_MAX_POS};
      end
      return res;
   endfunction

   // Magnitude of a signed amount, clamped to the one-cycle limit
   function automatic logic [4:0] dwss_magnitude
   (
      input logic [5:0] amount
   );
      logic [5:0] mag;
      mag = amount[5] ? (6'h00 - amount) : amount;
      if (mag > {1'b0, dwss_pkg::SHIFT_MAX})
      begin
         mag = {1'b0, dwss_pkg::SHIFT_MAX};
      end
      return mag[4:0];
   endfunction

   // Forty-bit shift; right shifts fill with sign only when arithmetic
   function automatic logic [39:0] dwss_shift
   (
      input logic [39:0] operand,
      input logic [4:0]  mag,
      input logic        right,
      input logic        arith
   );
      logic [39:0] res;
      res = operand;
      if (right && arith)
      begin
         res = 40'($signed(operand) >>> mag); // RQ13
      end
      else if (right)
      begin
         res = operand >> mag; // RQ13
      end
      else
      begin
         res = operand << mag; // RQ13
      end
      return res;
   endfunction

   // Next-state logic for both halves of the slice
   always_comb
   begin
      logic [16:0] sat_pick;
      logic [4:0]  mag;
      logic        right;
      logic        is_xbus;
      logic [39:0] operand;
      logic [39:0] shifted;
      sat_pick   = 17'h0_0000;
      mag        = 5'h00;
      right      = 1'b0;
      is_xbus    = 1'b0;
      operand    = 40'h00_0000_0000;
      shifted    = 40'h00_0000_0000;
      state_next = state_reg;

      // Stored word only; nothing here feeds back to the accumulator
      sat_pick = dwss_saturate(SAT_REQ_I.rnd_value, // RQ2 RQ3
                               SAT_REQ_I.src_acc[dwss_pkg::ACC_SIGN_BIT], // RQ6
                               SAT_REQ_I.acc_ovf | SAT_REQ_I.rnd_ovf, // RQ2
                               DATA_WRITE_SATURATION_ENABLE_I); // RQ7
      state_next.wr_valid = SAT_REQ_I.valid; // RQ1
      if (SAT_REQ_I.valid)
      begin
         state_next.wr_data = sat_pick[15:0]; // RQ4 RQ5
         state_next.wr_sat  = sat_pick[16];
      end

      // Direction from the sign, zero amount leaves the operand as is
      mag     = dwss_magnitude(SHF_REQ_I.amount); // RQ10
      right   = ~SHF_REQ_I.amount[5] && (SHF_REQ_I.amount != 6'h00); // RQ10
      is_xbus = 1'b0;

      // Operand select; X data sits high for right shifts, low otherwise
      unique case (SHF_REQ_I.src_sel)
         dwss_pkg::DWSS_SRC_ACC_A:
         begin
            operand = SHF_REQ_I.acc_a; // RQ9
         end
         dwss_pkg::DWSS_SRC_ACC_B:
         begin
            operand = SHF_REQ_I.acc_b; // RQ9
         end
         dwss_pkg::DWSS_SRC_XBUS:
         begin
            is_xbus = 1'b1;
            if (right)
            begin
               operand = {{8{SHF_REQ_I.arith & SHF_REQ_I.xbus[15]}}, SHF_REQ_I.xbus, 16'h0000}; // RQ12
            end
            else
            begin
               operand = {24'h00_0000, SHF_REQ_I.xbus}; // RQ12
            end
         end
         default:
         begin
            operand = 40'h00_0000_0000; // Illegal source reads as zero
         end
      endcase

      shifted = dwss_shift(operand, mag, right, SHF_REQ_I.arith); // RQ8
      state_next.shf_valid = SHF_REQ_I.valid;
      if (SHF_REQ_I.valid)
      begin
         state_next.shf_res = shifted; // RQ11
         // Sixteen-bit result taken from where the X data was placed
         if (is_xbus && right)
         begin
            state_next.shf_mcu = shifted[dwss_pkg::XBUS_RIGHT_LSB +: dwss_pkg::DATA_W]; // RQ11 RQ12
         end
         else
         begin
            state_next.shf_mcu = shifted[dwss_pkg::XBUS_LEFT_LSB +: dwss_pkg::DATA_W]; // RQ11 RQ12
         end
      end
   end

   // State register; reset wins even with the enable low
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         state_reg.wr_valid  <= 1'b0;
         state_reg.wr_data   <= dwss_pkg::RST_WR_DATA;
         state_reg.wr_sat    <= 1'b0;
         state_reg.shf_valid <= 1'b0;
         state_reg.shf_res   <= dwss_pkg::RST_SHF_RES;
         state_reg.shf_mcu   <= dwss_pkg::RST_SHF_MCU;
      end
      else if (CE_I)
      begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state flip-flops
   assign WR_VALID_O  = state_reg.wr_valid;
   assign WR_DATA_O   = state_reg.wr_data;
   assign WR_SAT_O    = state_reg.wr_sat;
   assign SHF_VALID_O = state_reg.shf_valid;
   assign SHF_RES_O   = state_reg.shf_res;
   assign SHF_MCU_O   = state_reg.shf_mcu;

   // Checks on the saturation stage
   default clocking dwss_cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);

   a_sat_pos_clamp: assert property ( // RQ4
      CE_I && SAT_REQ_I.valid && DATA_WRITE_SATURATION_ENABLE_I
      && (SAT_REQ_I.acc_ovf || SAT_REQ_I.rnd_ovf) && !SAT_REQ_I.src_acc[39]
      |=> WR_VALID_O && WR_SAT_O && (WR_DATA_O == 16'h7fff))
      else $error("positive overflow not clamped to 7fff");

   a_sat_neg_clamp: assert property ( // RQ5
      CE_I && SAT_REQ_I.valid && DATA_WRITE_SATURATION_ENABLE_I
      && (SAT_REQ_I.acc_ovf || SAT_REQ_I.rnd_ovf) && SAT_REQ_I.src_acc[39]
      |=> WR_VALID_O && WR_SAT_O && (WR_DATA_O == 16'h8000))
      else $error("negative overflow not clamped to 8000");

   a_sat_disabled_pass: assert property ( // RQ7
      CE_I && SAT_REQ_I.valid && !DATA_WRITE_SATURATION_ENABLE_I
      |=> !WR_SAT_O && (WR_DATA_O == $past(SAT_REQ_I.rnd_value)))
      else $error("disabled saturation altered the stored word");

   a_sat_clean_pass: assert property ( // RQ3
      CE_I && SAT_REQ_I.valid && !SAT_REQ_I.acc_ovf && !SAT_REQ_I.rnd_ovf
      |=> !WR_SAT_O && (WR_DATA_O == $past(SAT_REQ_I.rnd_value)))
      else $error("word without overflow was changed");

   // Checks on the shifter
   a_shift_zero_ident: assert property ( // RQ10
      CE_I && SHF_REQ_I.valid && (SHF_REQ_I.src_sel == dwss_pkg::DWSS_SRC_ACC_B)
      && (SHF_REQ_I.amount == 6'h00)
      |=> SHF_VALID_O && (SHF_RES_O == $past(SHF_REQ_I.acc_b)))
      else $error("zero shift changed the operand");

   a_shift_right_log: assert property ( // RQ8
      CE_I && SHF_REQ_I.valid && (SHF_REQ_I.src_sel == dwss_pkg::DWSS_SRC_ACC_A)
      && !SHF_REQ_I.arith && !SHF_REQ_I.amount[5] && (SHF_REQ_I.amount <= 6'h10)
      |=> SHF_RES_O == ($past(SHF_REQ_I.acc_a) >> $past(SHF_REQ_I.amount)))
      else $error("logical right shift result wrong");

   a_shift_left_acc: assert property ( // RQ10
      CE_I && SHF_REQ_I.valid && (SHF_REQ_I.src_sel == dwss_pkg::DWSS_SRC_ACC_A)
      && SHF_REQ_I.amount[5] && (SHF_REQ_I.amount >= 6'h30)
      |=> SHF_RES_O == ($past(SHF_REQ_I.acc_a) << (6'h00 - $past(SHF_REQ_I.amount))))
      else $error("left shift result wrong");

   a_shift_arith_sign: assert property ( // RQ13
      CE_I && SHF_REQ_I.valid && (SHF_REQ_I.src_sel == dwss_pkg::DWSS_SRC_ACC_B)
      && SHF_REQ_I.arith && !SHF_REQ_I.amount[5] && (SHF_REQ_I.amount != 6'h00)
      |=> (SHF_RES_O[39] == $past(SHF_REQ_I.acc_b[39]))
          && (SHF_RES_O[38] == $past(SHF_REQ_I.acc_b[39])))
      else $error("arithmetic right shift lost the sign");

   a_xbus_right_place: assert property ( // RQ12
      CE_I && SHF_REQ_I.valid && (SHF_REQ_I.src_sel == dwss_pkg::DWSS_SRC_XBUS)
      && !SHF_REQ_I.arith && !SHF_REQ_I.amount[5] && (SHF_REQ_I.amount <= 6'h10)
      && (SHF_REQ_I.amount != 6'h00)
      |=> SHF_MCU_O == ($past(SHF_REQ_I.xbus) >> $past(SHF_REQ_I.amount)))
      else $error("X bus right shift result wrong");

   a_xbus_left_place: assert property ( // RQ12
      CE_I && SHF_REQ_I.valid && (SHF_REQ_I.src_sel == dwss_pkg::DWSS_SRC_XBUS)
      && SHF_REQ_I.amount[5] && (SHF_REQ_I.amount >= 6'h30)
      |=> (SHF_MCU_O == 16'($past(SHF_REQ_I.xbus) << (6'h00 - $past(SHF_REQ_I.amount))))
          && (SHF_RES_O[39:32] == 8'h00))
      else $error("X bus left shift result wrong");

   a_shift_one_cycle: assert property ( // RQ8
      CE_I && SHF_REQ_I.valid |=> SHF_VALID_O)
      else $error("shift result not ready after one cycle");

   a_enable_freeze: assert property (
      !CE_I |=> $stable(WR_DATA_O) && $stable(SHF_RES_O) && $stable(SHF_VALID_O) && $stable(WR_VALID_O))
      else $error("state moved with clock enable low");

   // Store pulse one cycle after a request; pulses drop and words hold when CE_I is high and no request comes
   a_wr_valid_drop: assert property ( // RQ2
      CE_I && !SAT_REQ_I.valid
      |=> !WR_VALID_O && $stable(WR_DATA_O) && $stable(WR_SAT_O))
      else $error("store word moved without a request");

   a_wr_one_cycle: assert property ( // RQ2
      CE_I && SAT_REQ_I.valid |=> WR_VALID_O)
      else $error("store word not ready after one cycle");

   a_shf_valid_drop: assert property ( // RQ8
      CE_I && !SHF_REQ_I.valid
      |=> !SHF_VALID_O && $stable(SHF_RES_O) && $stable(SHF_MCU_O))
      else $error("shift result moved without a request");

   // Sign fill, clamped magnitudes, the accumulator low word and the illegal source
   a_xbus_arith_fill: assert property ( // RQ13
      CE_I && SHF_REQ_I.valid && (SHF_REQ_I.src_sel == dwss_pkg::DWSS_SRC_XBUS)
      && SHF_REQ_I.arith && !SHF_REQ_I.amount[5] && (SHF_REQ_I.amount != 6'h00)
      |=> SHF_RES_O[39:31] == {9{$past(SHF_REQ_I.xbus[15])}})
      else $error("X bus arithmetic right shift lost the sign");

   a_shift_arith_full: assert property ( // RQ13
      CE_I && SHF_REQ_I.valid && (SHF_REQ_I.src_sel == dwss_pkg::DWSS_SRC_ACC_A)
      && SHF_REQ_I.arith && !SHF_REQ_I.amount[5] && (SHF_REQ_I.amount <= 6'h10)
      |=> SHF_RES_O == 40'($signed($past(SHF_REQ_I.acc_a)) >>> $past(SHF_REQ_I.amount)))
      else $error("arithmetic right shift result wrong");

   a_shift_left_clamp: assert property ( // RQ8
      CE_I && SHF_REQ_I.valid && (SHF_REQ_I.src_sel == dwss_pkg::DWSS_SRC_ACC_B)
      && SHF_REQ_I.amount[5] && (SHF_REQ_I.amount < 6'h30)
      |=> SHF_RES_O == ($past(SHF_REQ_I.acc_b) << 16))
      else $error("left shift beyond sixteen not held at sixteen");

   a_acc_mcu_low: assert property ( // RQ11
      CE_I && SHF_REQ_I.valid && (SHF_REQ_I.src_sel == dwss_pkg::DWSS_SRC_ACC_A)
      && (SHF_REQ_I.amount == 6'h00)
      |=> SHF_MCU_O == $past(SHF_REQ_I.acc_a[15:0]))
      else $error("sixteen-bit accumulator result wrong");

   a_src_illegal_zero: assert property ( // RQ9
      CE_I && SHF_REQ_I.valid && (2'(SHF_REQ_I.src_sel) == 2'h3)
      |=> (SHF_RES_O == 40'h00_0000_0000) && (SHF_MCU_O == 16'h0000))
      else $error("illegal source gave a non-zero result");

endmodule

// >>> test/dwss_acc_model.sv
// Behavioural accumulators that feed the shifter slice.
// Assumes the bench loads them; the slice has no path back into them.
`timescale 1ns/100ps

module dwss_acc_model
(
   input  wire logic        clk_i,
   input  wire logic        load_i,
   input  wire logic [39:0] val_a_i,
   input  wire logic [39:0] val_b_i,
   output logic [39:0]      acc_a_o,
   output logic [39:0]      acc_b_o
);
   // Only a bench load changes them, so a store never disturbs them
   always_ff @(posedge clk_i)
   begin
      if (load_i)
      begin
         acc_a_o <= val_a_i;
         acc_b_o <= val_b_i;
      end
   end
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the write saturation and barrel shifter slice.
// Assumes one 100 MHz clock; inputs change 1 ns after each rising edge.
`timescale 1ns/100ps

module tb_top;
   logic                       clk;
   logic                       rst_n;
   logic                       ce;
   logic                       sat_en;
   logic                       load;
   logic                       ce_seen;
   logic [39:0]                va;
   logic [39:0]                vb;
   logic [39:0]                acc_a;
   logic [39:0]                acc_b;
   dwss_pkg::dwss_sat_req_type sat_req;
   dwss_pkg::dwss_shf_req_type shf_req;
   logic                       wr_valid;
   logic                       wr_sat;
   logic                       shf_valid;
   logic [15:0]                wr_data;
   logic [15:0]                shf_mcu;
   logic [39:0]                shf_res;
   logic [55:0]                wr_q[$];
   logic [55:0]                shf_q[$];
   logic [55:0]                last_wr;
   logic [55:0]                last_shf;
   int                         error_cnt;
   int                         samples_checked;

   dwss_acc_model u_acc (.clk_i(clk), .load_i(load), .val_a_i(va), .val_b_i(vb), .acc_a_o(acc_a), .acc_b_o(acc_b));
   dwss_top dut (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .DATA_WRITE_SATURATION_ENABLE_I(sat_en),
      .SAT_REQ_I(sat_req), .SHF_REQ_I(shf_req), .WR_VALID_O(wr_valid), .WR_DATA_O(wr_data),
      .WR_SAT_O(wr_sat), .SHF_VALID_O(shf_valid), .SHF_RES_O(shf_res), .SHF_MCU_O(shf_mcu));

   // Free-running core clock
   always #5 clk = ~clk;

   task automatic chk(input string what, input logic [55:0] exp, input logic [55:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask

   task automatic close_out();
      if (error_cnt == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Reference shift; amounts beyond sixteen saturate at sixteen
   function automatic logic [55:0] shf_exp(input dwss_pkg::dwss_shf_req_type r);
      logic [39:0] op;
      logic [5:0]  m;
      logic        rt;
      rt = !r.amount[5] && (r.amount != 6'h00);
      m = r.amount[5] ? 6'(-r.amount) : r.amount;
      if (m > 6'h10)
         m = 6'h10;
      case (r.src_sel)
         dwss_pkg::DWSS_SRC_ACC_A : op = r.acc_a;
         dwss_pkg::DWSS_SRC_ACC_B : op = r.acc_b;
         dwss_pkg::DWSS_SRC_XBUS  : op = rt ? {{8{r.arith & r.xbus[15]}}, r.xbus, 16'h0000}
                                            : {24'h000000, r.xbus};
         default                  : op = 40'h00_0000_0000;
      endcase
      if (rt)
         op = r.arith ? 40'($signed(op) >>> m) : op >> m;
      else
         op = op << m;
      return {op, (r.src_sel == dwss_pkg::DWSS_SRC_XBUS && rt) ? op[31:16] : op[15:0]};
   endfunction

   // One random cycle on both paths; notes land at the edge that takes them,
   // so the watcher never sees a note for a request not yet taken
   task automatic drive();
      dwss_pkg::dwss_sat_req_type s;
      dwss_pkg::dwss_shf_req_type h;
      #1;
      ce = ($urandom % 6) != 0;
      sat_en = 1'($urandom);
      load = 1'($urandom);
      va = {8'($urandom), $urandom};
      vb = {8'($urandom), $urandom};
      s = {1'($urandom), 16'($urandom), 8'($urandom), $urandom, 1'($urandom % 3 == 0), 1'($urandom % 3 == 0)};
      h = {1'($urandom), 2'($urandom), 1'($urandom), 6'($urandom), acc_a, acc_b, 16'($urandom)};
      sat_req = s;
      shf_req = h;
      @(posedge clk);
      if (ce && s.valid)
         wr_q.push_back((sat_en && (s.acc_ovf || s.rnd_ovf)) ? {1'b1, s.src_acc[39] ? 16'h8000 : 16'h7fff}
                                                               : {1'b0, s.rnd_value});
      if (ce && h.valid)
         shf_q.push_back(shf_exp(h));
   endtask

   always @(posedge clk)
      ce_seen <= ce;

   // Watcher: a pulse one cycle after each taken request, words hold otherwise
   always @(negedge clk)
   begin
      if (rst_n === 1'b0)
      begin
         last_wr = 56'h0;
         last_shf = 56'h0;
      end
      else if (ce_seen === 1'b1)
      begin
         chk("wr_valid", 56'(wr_q.size() != 0), 56'(wr_valid));
         if (wr_q.size() != 0)
            last_wr = wr_q.pop_front();
         chk("wr_word", last_wr, {wr_sat, wr_data});
         chk("shf_valid", 56'(shf_q.size() != 0), 56'(shf_valid));
         if (shf_q.size() != 0)
            last_shf = shf_q.pop_front();
         chk("shf_out", last_shf, {shf_res, shf_mcu});
      end
   end

   // Main sequence with a reset in mid-run
   initial
   begin
      {clk, rst_n, sat_en} = 3'h0;
      {ce, load} = 2'h3;
      {va, vb} = 80'h0;
      sat_req = '0;
      shf_req = '0;
      error_cnt = 0;
      samples_checked = 0;
      void'($urandom(61224));
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      @(posedge clk);
      repeat (600) drive();
      // Drop the last request before the next edge takes it a second time
      #1 {ce, sat_req.valid, shf_req.valid} = 3'h4;
      @(posedge clk);
      #1 rst_n = 1'b0;
      @(posedge clk);
      #1 chk("rst_outs", 56'h0, {wr_valid, wr_sat, wr_data, shf_valid, shf_mcu});
      chk("rst_res", 56'h0, shf_res);
      rst_n = 1'b1;
      @(posedge clk);
      repeat (200) drive();
      #1 {ce, sat_req.valid, shf_req.valid} = 3'h4;
      repeat (3) @(posedge clk);
      close_out();
   end
endmodule
